/* File: hdl/dfp_pkg.sv */
// Constants and types of the drive fault protection block
package dfp_pkg;
    // Timing: one protection tick is 0.1 s
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 100_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam logic [3:0] GND_DELAY_TICKS = 4'h5;
    localparam logic [3:0] GND_TEST_TICKS = 4'h2;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OL_GAIN = 8'h04;
    localparam logic [7:0] ADDR_OL_WARN = 8'h08;
    localparam logic [7:0] ADDR_OV_GAIN = 8'h0C;
    localparam logic [7:0] ADDR_OV_THR = 8'h10;
    localparam logic [7:0] ADDR_OC_GAIN = 8'h14;
    localparam logic [7:0] ADDR_OC_THR = 8'h18;
    localparam logic [7:0] ADDR_FW_COEFF = 8'h1C;
    localparam logic [7:0] ADDR_AR_COUNT = 8'h20;
    localparam logic [7:0] ADDR_AR_INTERVAL = 8'h24;
    localparam logic [7:0] ADDR_RATED_FREQ = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    localparam logic [7:0] ADDR_INT_STAT = 8'h30;
    localparam logic [7:0] ADDR_INT_MASK = 8'h34;
    localparam logic [7:0] ADDR_OL_ACC = 8'h38;

    // Control register fields
    localparam int CTRL_OL_SEL = 0;
    localparam int CTRL_GND_SEL = 1;
    localparam int CTRL_FOUT_SEL = 2;
    localparam int CTRL_INPL_SEL = 3;
    localparam int CTRL_OUTPL_SEL = 4;
    localparam int CTRL_MAN_RST = 5;

    // Interrupt status fields
    localparam int INT_OL_WARN = 0;
    localparam int INT_FAULT = 1;
    localparam int INT_AUTO_RST = 2;
    localparam int INT_LATCH = 3;
    localparam int INT_STALL = 4;

    // Reset values and ranges
    localparam logic [4:0] CTRL_RST = 5'h1F;
    localparam logic [9:0] OL_GAIN_RST = 10'h064;
    localparam logic [9:0] OL_GAIN_MIN = 10'h014;
    localparam logic [9:0] OL_GAIN_MAX = 10'h3E8;
    localparam logic [9:0] OL_WARN_RST = 10'h050;
    localparam logic [9:0] OL_WARN_MIN = 10'h032;
    localparam logic [9:0] OL_WARN_MAX = 10'h064;
    localparam logic [9:0] OV_GAIN_RST = 10'h01E;
    localparam logic [9:0] OV_GAIN_MAX = 10'h064;
    localparam logic [9:0] OV_THR_RST = 10'h2F8;
    localparam logic [9:0] OV_THR_220 = 10'h1A0;
    localparam logic [9:0] OV_THR_380 = 10'h2F8;
    localparam logic [9:0] OV_THR_480 = 10'h379;
    localparam logic [9:0] OC_GAIN_RST = 10'h014;
    localparam logic [9:0] OC_GAIN_MAX = 10'h064;
    localparam logic [9:0] OC_THR_RST = 10'h096;
    localparam logic [9:0] OC_THR_MIN = 10'h064;
    localparam logic [9:0] OC_THR_MAX = 10'h0C8;
    localparam logic [9:0] FW_RST = 10'h0C8;
    localparam logic [9:0] FW_MIN = 10'h032;
    localparam logic [9:0] FW_MAX = 10'h12C;
    localparam logic [4:0] AR_COUNT_RST = 5'h00;
    localparam logic [4:0] AR_COUNT_MAX = 5'h14;
    localparam logic [9:0] AR_INT_RST = 10'h00A;
    localparam logic [9:0] AR_INT_MIN = 10'h001;
    localparam logic [9:0] AR_INT_MAX = 10'h3E8;
    localparam logic [15:0] RATED_FREQ_RST = 16'h1388;

    // Overload curve, current levels in 0.1 % of rated current
    localparam logic [16:0] OL_LIMIT = 17'h08CA0;
    localparam logic [11:0] OL_LVL_HI = 12'h898;
    localparam logic [11:0] OL_LVL_MID = 12'h73A;
    localparam logic [11:0] OL_LVL_LO = 12'h5DC;
    localparam logic [16:0] OL_RATE_HI = 17'h0003C;
    localparam logic [16:0] OL_RATE_MID = 17'h00008;
    localparam logic [16:0] OL_RATE_LO = 17'h00001;

    // Supply classes
    localparam logic [1:0] CLASS_1P220 = 2'h0;
    localparam logic [1:0] CLASS_3P220 = 2'h1;
    localparam logic [1:0] CLASS_3P380 = 2'h2;

    typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_LATCH} dfp_state_type;
    typedef enum logic [1:0] {GP_DELAY, GP_TEST, GP_DONE} dfp_gnd_type;

    typedef struct packed {
        logic [11:0] current;
        logic [9:0] bus_v;
        logic [15:0] freq;
        logic accel;
        logic decel;
    } dfp_meas_type;
endpackage

/* File: hdl/dfp_top.sv */
// Drive fault protection: overload, stall, ground check, auto reset
`timescale 1ns/1ps
// Functional notes
// - Overload check off at 0, curve at 1
// - Trip 220% one minute, 150% sixty minutes
// - Overload gain scales curve current axis
// - Prewarning when accumulation exceeds curve times coefficient
// - Hold frequency while decelerating above voltage threshold
// - Overvoltage stall off when its gain zero
// - Threshold default chosen by supply class
// - Reduce frequency while accelerating or decelerating at current stall threshold
// - Overcurrent stall off when its gain zero
// - Above rated frequency limit scaled by ratio
// - Ground short test drives phases after power-up
// - Auto reset count limited, then stay latched
// - Fault output during auto reset selectable
// - Wait interval before each auto reset
// - Input phase loss only above 30 kW
// - Output phase loss protection selectable
module dfp_top #(
    parameter int TICK_CYCLES = dfp_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic NRST_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Drive measurements and straps
    input wire dfp_pkg::dfp_meas_type MEAS_I,
    input wire logic [1:0] SUPPLY_CLASS_I,
    input wire logic MODEL_ABOVE_30KW_I,
    input wire logic GND_SHORT_I,
    input wire logic IN_PHASE_LOSS_I,
    input wire logic OUT_PHASE_LOSS_I,
    // Control outputs
    output logic OL_WARN_O,
    output logic FREQ_HOLD_O,
    output logic FREQ_REDUCE_O,
    output logic GND_TEST_O,
    output logic FAULT_O,
    output logic AUTO_RESET_O,
    output logic IRQ_O
);
    import dfp_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    function automatic logic [9:0] clampf(
        input logic [31:0] v,
        input logic [9:0] lo,
        input logic [9:0] hi
    );
        logic [9:0] r;
        if (v < {22'h0, lo}) begin
            r = lo;
        end else if (v > {22'h0, hi}) begin
            r = hi;
        end else begin
            r = v[9:0];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Registers
    logic [4:0] ctrl_r;
    logic [9:0] ol_gain_r, ol_warn_r, ov_gain_r, ov_thr_r;
    logic [9:0] oc_gain_r, oc_thr_r, fw_r, ar_int_r;
    logic [4:0] ar_count_r;
    logic [15:0] rated_r;
    logic [4:0] int_stat_r, int_mask_r, int_set;
    logic class_done_r;
    logic [31:0] rdata_r, rdata_nxt;
    logic [TW-1:0] tick_cnt_r;
    logic tick;
    logic [16:0] acc_r, acc_nxt, acc_rate;
    dfp_state_type st_r, st_nxt;
    dfp_gnd_type gp_r;
    logic [3:0] gnd_cnt_r;
    logic [4:0] attempts_r;
    logic [9:0] wait_r;
    logic [2:0] cause_r;
    logic warn_r, hold_r, reduce_r, fault_out_r, auto_rst_r;

    ////////////////////////////////////////////////////////////////
    // Bus decode
    wire wr_ctrl = WR_I && ADDR_I == ADDR_CTRL;
    wire man_rst = wr_ctrl && WDATA_I[CTRL_MAN_RST];
    wire rd_int = RD_I && ADDR_I == ADDR_INT_STAT;
    wire ol_sel = ctrl_r[CTRL_OL_SEL];
    wire fout_sel = ctrl_r[CTRL_FOUT_SEL];

    always_comb begin
        case (ADDR_I)
            ADDR_CTRL: rdata_nxt = {27'h0, ctrl_r};
            ADDR_OL_GAIN: rdata_nxt = {22'h0, ol_gain_r};
            ADDR_OL_WARN: rdata_nxt = {22'h0, ol_warn_r};
            ADDR_OV_GAIN: rdata_nxt = {22'h0, ov_gain_r};
            ADDR_OV_THR: rdata_nxt = {22'h0, ov_thr_r};
            ADDR_OC_GAIN: rdata_nxt = {22'h0, oc_gain_r};
            ADDR_OC_THR: rdata_nxt = {22'h0, oc_thr_r};
            ADDR_FW_COEFF: rdata_nxt = {22'h0, fw_r};
            ADDR_AR_COUNT: rdata_nxt = {27'h0, ar_count_r};
            ADDR_AR_INTERVAL: rdata_nxt = {22'h0, ar_int_r};
            ADDR_RATED_FREQ: rdata_nxt = {16'h0, rated_r};
            ADDR_STATUS: rdata_nxt = {16'h0, cause_r, attempts_r,
                gp_r, st_r, warn_r, hold_r, reduce_r, fault_out_r};
            ADDR_INT_STAT: rdata_nxt = {27'h0, int_stat_r};
            ADDR_INT_MASK: rdata_nxt = {27'h0, int_mask_r};
            ADDR_OL_ACC: rdata_nxt = {15'h0, acc_r};
            default: rdata_nxt = 32'h0;
        endcase
    end

    // Configuration writes, values clamped to their ranges
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            ctrl_r <= CTRL_RST;
            ol_gain_r <= OL_GAIN_RST;
            ol_warn_r <= OL_WARN_RST;
            ov_gain_r <= OV_GAIN_RST;
            oc_gain_r <= OC_GAIN_RST;
            oc_thr_r <= OC_THR_RST;
            fw_r <= FW_RST;
            ar_count_r <= AR_COUNT_RST;
            ar_int_r <= AR_INT_RST;
            rated_r <= RATED_FREQ_RST;
            int_mask_r <= 5'h00;
        end else if (WR_I) begin
            case (ADDR_I)
                ADDR_CTRL: ctrl_r <= WDATA_I[4:0];
                ADDR_OL_GAIN: ol_gain_r <=
                    clampf(WDATA_I, OL_GAIN_MIN, OL_GAIN_MAX);
                ADDR_OL_WARN: ol_warn_r <=
                    clampf(WDATA_I, OL_WARN_MIN, OL_WARN_MAX);
                ADDR_OV_GAIN: ov_gain_r <=
                    clampf(WDATA_I, 10'h000, OV_GAIN_MAX);
                ADDR_OC_GAIN: oc_gain_r <=
                    clampf(WDATA_I, 10'h000, OC_GAIN_MAX);
                ADDR_OC_THR: oc_thr_r <=
                    clampf(WDATA_I, OC_THR_MIN, OC_THR_MAX);
                ADDR_FW_COEFF: fw_r <= clampf(WDATA_I, FW_MIN, FW_MAX);
                ADDR_AR_COUNT: ar_count_r <=
                    5'(clampf(WDATA_I, 10'h000, {5'h0, AR_COUNT_MAX}));
                ADDR_AR_INTERVAL: ar_int_r <=
                    clampf(WDATA_I, AR_INT_MIN, AR_INT_MAX);
                ADDR_RATED_FREQ: rated_r <= WDATA_I[15:0];
                ADDR_INT_MASK: int_mask_r <= WDATA_I[4:0];
                default: ;
            endcase
        end
    end

    wire [9:0] class_thr = (SUPPLY_CLASS_I == CLASS_1P220 ||
        SUPPLY_CLASS_I == CLASS_3P220) ? OV_THR_220 :
        (SUPPLY_CLASS_I == CLASS_3P380) ? OV_THR_380 : OV_THR_480;

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            ov_thr_r <= OV_THR_RST;
            class_done_r <= 1'b0;
        end else begin
            class_done_r <= 1'b1;
            if (!class_done_r) begin
                ov_thr_r <= class_thr;
            end else if (WR_I && ADDR_I == ADDR_OV_THR) begin
                ov_thr_r <= WDATA_I[9:0];
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= RD_I ? rdata_nxt : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Protection tick
    assign tick = tick_cnt_r == TW'(TICK_CYCLES - 1);

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Inverse-time overload
    // current scaled by gain
    wire [23:0] cur_x100 = 24'(MEAS_I.current) * 24'h000064;
    wire [23:0] gain_w = {14'h0, ol_gain_r};
    wire ol_hi = cur_x100 >= 24'(OL_LVL_HI) * gain_w;
    wire ol_mid = cur_x100 >= 24'(OL_LVL_MID) * gain_w;
    wire ol_lo = cur_x100 >= 24'(OL_LVL_LO) * gain_w;
    wire ol_trip = ol_sel && acc_r >= OL_LIMIT;
    wire ol_warn_hit = ol_sel && 24'(acc_r) * 24'h000064 >
        24'(OL_LIMIT) * {14'h0, ol_warn_r};

    assign acc_rate = ol_hi ? OL_RATE_HI :
        ol_mid ? OL_RATE_MID : OL_RATE_LO;

    always_comb begin
        acc_nxt = acc_r;
        if (!ol_sel || man_rst || auto_rst_r) begin
            acc_nxt = 17'h0;
        end else if (tick && ol_lo) begin
            acc_nxt = (acc_r + acc_rate > OL_LIMIT) ? OL_LIMIT :
                acc_r + acc_rate;
        end else if (tick && acc_r != 17'h0) begin
            acc_nxt = acc_r - 17'h1;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            acc_r <= 17'h0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Stall control
    // overvoltage hold
    wire ov_stall = MEAS_I.decel && ov_gain_r != 10'h0 &&
        MEAS_I.bus_v > ov_thr_r;
    wire above_rated = MEAS_I.freq > rated_r;
    wire [39:0] oc_lhs = 40'(MEAS_I.current) * 40'(rated_r) *
        40'h64;
    wire [39:0] oc_rhs = 40'(MEAS_I.freq) * 40'(fw_r) *
        40'(oc_thr_r) * 40'hA;
    wire [15:0] oc_base = 16'(oc_thr_r) * 16'hA;
    wire oc_hit = above_rated ? oc_lhs >= oc_rhs :
        {4'h0, MEAS_I.current} >= oc_base;
    wire oc_stall = (MEAS_I.accel || MEAS_I.decel) &&
        oc_gain_r != 10'h0 && oc_hit;

    ////////////////////////////////////////////////////////////////
    // Power-up ground check
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            gp_r <= GP_DELAY;
            gnd_cnt_r <= 4'h0;
        end else begin
            case (gp_r)
                GP_DELAY: begin
                    if (!ctrl_r[CTRL_GND_SEL]) begin
                        gp_r <= GP_DONE;
                    end else if (tick) begin
                        gnd_cnt_r <= gnd_cnt_r + 4'h1;
                        if (gnd_cnt_r == GND_DELAY_TICKS - 4'h1) begin
                            gp_r <= GP_TEST;
                            gnd_cnt_r <= 4'h0;
                        end
                    end
                end
                GP_TEST: begin
                    if (GND_SHORT_I) begin
                        gp_r <= GP_DONE;
                    end else if (tick) begin
                        gnd_cnt_r <= gnd_cnt_r + 4'h1;
                        if (gnd_cnt_r == GND_TEST_TICKS - 4'h1) begin
                            gp_r <= GP_DONE;
                        end
                    end
                end
                GP_DONE: gp_r <= GP_DONE;
                default: gp_r <= GP_DONE;
            endcase
        end
    end

    wire gnd_fault = gp_r == GP_TEST && GND_SHORT_I;
    wire inpl_fault = ctrl_r[CTRL_INPL_SEL] && MODEL_ABOVE_30KW_I &&
        IN_PHASE_LOSS_I;
    wire outpl_fault = ctrl_r[CTRL_OUTPL_SEL] && OUT_PHASE_LOSS_I;
    wire any_fault = ol_trip || gnd_fault || inpl_fault || outpl_fault;
    wire [2:0] cause_w = {inpl_fault || outpl_fault,
        gnd_fault || outpl_fault, ol_trip};

    ////////////////////////////////////////////////////////////////
    // Fault and auto reset sequencing
    wire new_fault = st_r == ST_RUN && any_fault;
    wire wait_done = st_r == ST_WAIT && tick && wait_r + 10'h1 >= ar_int_r;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN: begin
                if (any_fault) begin
                    st_nxt = (attempts_r < ar_count_r) ? ST_WAIT :
                        ST_LATCH;
                end
            end
            ST_WAIT: begin
                if (wait_done) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_LATCH: st_nxt = ST_LATCH;
            default: st_nxt = ST_RUN;
        endcase
        if (man_rst) begin
            st_nxt = ST_RUN;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            st_r <= ST_RUN;
            attempts_r <= 5'h0;
            wait_r <= 10'h0;
            cause_r <= 3'h0;
            auto_rst_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            auto_rst_r <= wait_done && !man_rst;
            if (new_fault) begin
                cause_r <= cause_w;
            end
            if (man_rst) begin
                attempts_r <= 5'h0;
                wait_r <= 10'h0;
            end else if (wait_done) begin
                attempts_r <= attempts_r + 5'h1;
                wait_r <= 10'h0;
            end else if (st_r == ST_WAIT && tick) begin
                wait_r <= wait_r + 10'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs and interrupts
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            warn_r <= 1'b0;
            hold_r <= 1'b0;
            reduce_r <= 1'b0;
            fault_out_r <= 1'b0;
        end else begin
            warn_r <= ol_warn_hit;
            hold_r <= ov_stall;
            reduce_r <= oc_stall;
            fault_out_r <= st_nxt == ST_LATCH ||
                (st_nxt == ST_WAIT && fout_sel);
        end
    end

    assign int_set = {(ov_stall && !hold_r) || (oc_stall && !reduce_r),
        st_nxt == ST_LATCH && st_r != ST_LATCH, auto_rst_r,
        new_fault, ol_warn_hit && !warn_r};

    // Read clears, a new event in the same cycle wins
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            int_stat_r <= 5'h00;
        end else begin
            int_stat_r <= (rd_int ? 5'h00 : int_stat_r) | int_set;
        end
    end

    assign IRQ_O = |(int_stat_r & int_mask_r);
    assign RDATA_O = rdata_r;
    assign OL_WARN_O = warn_r;
    assign FREQ_HOLD_O = hold_r;
    assign FREQ_REDUCE_O = reduce_r;
    assign GND_TEST_O = gp_r == GP_TEST;
    assign FAULT_O = fault_out_r;
    assign AUTO_RESET_O = auto_rst_r;

    ////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_fault_seen;
        st_r == ST_RUN && any_fault && !man_rst;
    endsequence

    property p_ol_off;
        !ol_sel |=> acc_r == 17'h0 ##1 !OL_WARN_O;
    endproperty
    a_ol_off: assert property (p_ol_off)
        else $error("overload accumulates while disabled");

    property p_ol_trip;
        s_fault_seen and ol_trip |=> st_r != ST_RUN;
    endproperty
    a_ol_trip: assert property (p_ol_trip)
        else $error("overload limit did not raise a fault");

    property p_warn;
        ol_warn_hit |=> OL_WARN_O;
    endproperty
    a_warn: assert property (p_warn)
        else $error("overload warning missing");

    property p_ov_hold;
        MEAS_I.decel && ov_gain_r != 10'h0 && MEAS_I.bus_v > ov_thr_r
            |=> FREQ_HOLD_O;
    endproperty
    a_ov_hold: assert property (p_ov_hold)
        else $error("no frequency hold above threshold");

    property p_ov_off;
        ov_gain_r == 10'h0 |=> !FREQ_HOLD_O;
    endproperty
    a_ov_off: assert property (p_ov_off)
        else $error("overvoltage stall active at zero gain");

    property p_oc_off;
        oc_gain_r == 10'h0 |=> !FREQ_REDUCE_O;
    endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("overcurrent stall active at zero gain");

    property p_latch;
        s_fault_seen and attempts_r >= ar_count_r |=>
            st_r == ST_LATCH && FAULT_O;
    endproperty
    a_latch: assert property (p_latch)
        else $error("fault not latched after attempts");

    property p_fout_off;
        st_r == ST_WAIT && !fout_sel && !$past(fout_sel) |-> !FAULT_O;
    endproperty
    a_fout_off: assert property (p_fout_off)
        else $error("fault output active during auto reset");

    property p_manual;
        man_rst |=> st_r == ST_RUN && attempts_r == 5'h0 &&
            wait_r == 10'h0;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual reset did not clear sequencing");

    property p_inpl;
        !MODEL_ABOVE_30KW_I && st_r == ST_RUN && !man_rst && !ol_trip &&
            !gnd_fault && !outpl_fault |=> st_r == ST_RUN;
    endproperty
    a_inpl: assert property (p_inpl)
        else $error("input phase loss fault on small model");
endmodule // dfp_top

/* File: sim/dfp_motor_model.sv */
// Motor and supply model feeding the protection block
`timescale 1ns/1ps
module dfp_motor_model (
    // Operating point
    input wire logic [11:0] cur_i,
    input wire logic [9:0] bus_i,
    input wire logic [15:0] freq_i,
    input wire logic accel_i,
    input wire logic decel_i,
    input wire logic short_i,
    // Drive side
    input wire logic gnd_test_i,
    output dfp_pkg::dfp_meas_type meas_o,
    output logic gnd_short_o
);
    import dfp_pkg::*;
    assign meas_o = {cur_i, bus_i, freq_i, accel_i, decel_i};
    assign gnd_short_o = short_i & gnd_test_i;
endmodule // dfp_motor_model

/* File: sim/drive_fault_protection_bench.sv */
// Self-checking bench of the drive fault protection block
`timescale 1ns/1ps
module drive_fault_protection_bench;
    import dfp_pkg::*;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, acc = 0, dec = 0, shrt = 0;
    logic inpl = 0, outpl = 0, warn, hold, reduce, gtest, fault, arst, irq;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [11:0] cur = 0;
    logic [9:0] bus = 10'h12C;
    logic [15:0] freq = 16'h1388;
    logic gshort;
    logic big = 0;
    logic [1:0] cls = 2'h2;
    dfp_meas_type meas;
    int miscompares = 0, n_compared = 0, cyc = 0, i, t0;
    always #12.5 clk = ~clk;
    dfp_motor_model motor (.cur_i(cur), .bus_i(bus), .freq_i(freq),
        .accel_i(acc), .decel_i(dec), .short_i(shrt), .gnd_test_i(gtest),
        .meas_o(meas), .gnd_short_o(gshort));
    dfp_top #(.TICK_CYCLES(10)) uut (.MCLK_I(clk), .NRST_I(nrst),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .MEAS_I(meas), .SUPPLY_CLASS_I(cls),
        .MODEL_ABOVE_30KW_I(big), .GND_SHORT_I(gshort),
        .IN_PHASE_LOSS_I(inpl), .OUT_PHASE_LOSS_I(outpl),
        .OL_WARN_O(warn), .FREQ_HOLD_O(hold), .FREQ_REDUCE_O(reduce),
        .GND_TEST_O(gtest), .FAULT_O(fault), .AUTO_RESET_O(arst),
        .IRQ_O(irq));
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 cmp(rdata, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse_loss;
        @(posedge clk);
        outpl <= 1;
        @(posedge clk);
        outpl <= 0;
        step(3);
    endtask
    task automatic wait_arst;
        for (i = 0; i < 60 && arst !== 1'b1; i++) step(1);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        for (i = 0; i < 100 && gtest !== 1'b1; i++) step(1);
        cmp(gtest, 1);
        rreg(ADDR_CTRL, 32'h1F);
        rreg(ADDR_OV_THR, 32'h2F8);
        rreg(8'h3C, 0);
        rreg(ADDR_OC_GAIN, 32'h14);
        wreg(ADDR_INT_MASK, 32'h1A);
        @(posedge clk);
        dec <= 1;
        bus <= 10'h302;
        step(3);
        cmp(hold, 1);
        @(posedge clk);
        bus <= 10'h2BC;
        step(3);
        cmp(hold, 0);
        wreg(ADDR_OV_GAIN, 0);
        bus <= 10'h302;
        step(3);
        cmp(hold, 0);
        @(posedge clk);
        dec <= 0;
        acc <= 1;
        cur <= 12'h5DC;
        step(3);
        cmp(reduce, 1);
        cmp(irq, 1);
        rreg(ADDR_INT_STAT, 32'h10);
        step(1);
        cmp(irq, 0);
        @(posedge clk);
        freq <= 16'h2710;
        step(3);
        cmp(reduce, 0);
        @(posedge clk);
        freq <= 16'h1770;
        cur <= 12'hE10;
        step(3);
        cmp(reduce, 1);
        @(posedge clk);
        cur <= 12'hE0F;
        step(3);
        cmp(reduce, 0);
        @(posedge clk);
        freq <= 16'h1388;
        cur <= 12'h5DC;
        wreg(ADDR_OC_GAIN, 0);
        step(3);
        cmp(reduce, 0);
        @(posedge clk);
        acc <= 0;
        inpl <= 1;
        step(3);
        cmp(fault, 0);
        @(posedge clk);
        big <= 1;
        step(3);
        cmp(fault, 1);
        rreg(ADDR_STATUS, 32'h80A1);
        @(posedge clk);
        inpl <= 0;
        big <= 0;
        wreg(ADDR_CTRL, 32'h3F);
        wreg(ADDR_AR_COUNT, 1);
        wreg(ADDR_AR_INTERVAL, 3);
        wreg(ADDR_CTRL, 32'h0F);
        pulse_loss();
        cmp(fault, 0);
        wreg(ADDR_CTRL, 32'h1F);
        t0 = cyc;
        pulse_loss();
        cmp(fault, 1);
        wait_arst();
        cmp(arst, 1);
        cmp((cyc - t0 > 21) && (cyc - t0 < 35), 1);
        pulse_loss();
        step(40);
        cmp(fault, 1);
        wreg(ADDR_CTRL, 32'h3B);
        step(2);
        cmp(fault, 0);
        pulse_loss();
        cmp(fault, 0);
        wait_arst();
        cmp(arst, 1);
        wreg(ADDR_CTRL, 32'h1F);
        @(posedge clk);
        cur <= 12'h898;
        t0 = cyc;
        for (i = 0; i < 7000 && warn !== 1'b1; i++) step(1);
        cmp(warn, 1);
        cmp((cyc - t0 > 4750) && (cyc - t0 < 4850), 1);
        cmp(fault, 0);
        for (i = 0; i < 2000 && fault !== 1'b1; i++) step(1);
        cmp(fault, 1);
        cmp((cyc - t0 > 5950) && (cyc - t0 < 6050), 1);
        wreg(ADDR_CTRL, 32'h1E);
        rreg(ADDR_OL_ACC, 0);
        @(posedge clk);
        nrst <= 0;
        cls <= 2'h3;
        shrt <= 1;
        repeat (4) @(posedge clk);
        nrst <= 1;
        step(2);
        rreg(ADDR_OV_THR, 32'h379);
        for (i = 0; i < 100 && fault !== 1'b1; i++) step(1);
        cmp(fault, 1);
        rreg(ADDR_STATUS, 32'h40A1);
        report_and_stop();
    end
endmodule // drive_fault_protection_bench
